// ===== include/isc_pkg.sv
// Shared constants and types for the in-line security control bank.
// Assumes a 16-bit register word reached through the serial configuration port.
package isc_pkg;

	// Register addresses on the serial configuration port
	localparam logic [5:0] ISC_ADDR_MAIN = 6'h19;
	localparam logic [5:0] ISC_ADDR_LEN = 6'h1a;

	// Values after reset and writable bit masks
	localparam logic [15:0] ISC_MAIN_RESET = 16'h03c4;
	localparam logic [15:0] ISC_LEN_RESET = 16'h0000;
	localparam logic [15:0] ISC_MAIN_MASK = 16'h03ff;
	localparam logic [15:0] ISC_LEN_MASK = 16'h7f7f;

	// Field positions in security_control_main
	localparam int ISC_GUARD_BIT = 9;
	localparam int ISC_HEAD_BIT = 8;
	localparam int ISC_SAKEY_BIT = 7;
	localparam int ISC_TXKEY_BIT = 6;
	localparam int ISC_RXKEY_BIT = 5;
	localparam int ISC_TAG_LSB = 2;
	localparam int ISC_MODE_LSB = 0;

	// Field positions in security_length_control
	localparam int ISC_TXL_LSB = 8;
	localparam int ISC_RXL_LSB = 0;

	// Serial frame layout: command byte then a 16-bit word
	localparam logic [4:0] ISC_CMD_BITS = 5'd8;
	localparam logic [4:0] ISC_FRAME_BITS = 5'd24;
	localparam int ISC_RAM_FLAG_BIT = 7;
	localparam int ISC_READ_FLAG_BIT = 6;

	// Head length byte subtracts this on transmit
	localparam logic [7:0] ISC_TX_HEAD_ADJ = 8'h02;
	// Tag byte count is code*2 plus this
	localparam logic [4:0] ISC_TAG_BASE = 5'd2;

	typedef enum logic [1:0] {
		ISC_MODE_OFF = 2'h0,
		ISC_MODE_CBCMAC = 2'h1,
		ISC_MODE_CTR = 2'h2,
		ISC_MODE_CCM = 2'h3
	} isc_mode_t;

	// Configuration presented to the security datapath
	typedef struct packed {
		isc_mode_t mode;
		logic rx_guard_en;
		logic sa_key;
		logic tx_key;
		logic rx_key;
		logic [4:0] tag_bytes;
		logic tag_code_bad;
		logic head_en;
		logic [7:0] tx_head_byte;
		logic [7:0] rx_head_byte;
		logic [6:0] tx_clear_skip;
		logic [6:0] rx_clear_skip;
		logic [6:0] tx_auth_only;
		logic [6:0] rx_auth_only;
	} isc_cfg_t;

endpackage

// ===== rtl/isc_core.sv
// In-line security control registers behind the serial configuration port.
// Assumes spi pins come from another domain and a frame length from same-clock logic.
`timescale 1ns/1ns
module isc_core (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_spi_csn_n,
	input wire logic i_spi_sclk,
	input wire logic i_spi_si,
	output logic o_spi_so,
	output logic o_spi_so_oe,
	input wire logic [6:0] i_frame_length,
	input wire logic i_standalone,
	output isc_pkg::isc_cfg_t o_cfg
);
	import isc_pkg::*;

	logic [1:0] csn_sync;
	logic [2:0] sclk_sync;
	logic [1:0] si_sync;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_on;
	logic [4:0] bit_cnt;
	logic [15:0] shift_in;
	logic [15:0] shift_out;
	logic [5:0] cmd_addr;
	logic cmd_read;
	logic cmd_ram;
	logic [15:0] sec_main;
	logic [15:0] sec_len;
	logic [15:0] read_word;
	logic [15:0] wr_word;
	logic wr_commit;
	isc_cfg_t next_cfg;
	isc_mode_t mode;
	logic [6:0] txl;
	logic [6:0] rxl;
	logic [2:0] tag_code;

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			csn_sync <= 2'h3;
			sclk_sync <= 3'h0;
			si_sync <= 2'h0;
		end else begin
			csn_sync <= {csn_sync[0], i_spi_csn_n};
			sclk_sync <= {sclk_sync[1:0], i_spi_sclk};
			si_sync <= {si_sync[0], i_spi_si};
		end
	end

	// Edges of the synchronised serial clock, qualified by select
	assign frame_on = !csn_sync[1];
	assign sclk_rise = frame_on && sclk_sync[1] && !sclk_sync[2];
	assign sclk_fall = frame_on && !sclk_sync[1] && sclk_sync[2];

	// Bit counter; deselect restarts the frame
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_cnt <= 5'h00;
		end else if (!frame_on) begin
			bit_cnt <= 5'h00;
		end else if (sclk_rise && bit_cnt != ISC_FRAME_BITS) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// Incoming bits, most significant first
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shift_in <= 16'h0000;
		end else if (sclk_rise) begin
			shift_in <= {shift_in[14:0], si_sync[1]};
		end
	end

	// Command byte captured once its eighth bit arrives
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_addr <= 6'h00;
			cmd_read <= 1'b0;
			cmd_ram <= 1'b0;
		end else if (sclk_rise && bit_cnt == ISC_CMD_BITS - 5'h01) begin
			cmd_addr <= {shift_in[4:0], si_sync[1]};
			cmd_read <= shift_in[ISC_READ_FLAG_BIT - 1];
			cmd_ram <= shift_in[ISC_RAM_FLAG_BIT - 1];
		end
	end

	// Read mux; reserved bits always read zero
	always_comb begin
		read_word = 16'h0000;
		if (!cmd_ram && cmd_addr == ISC_ADDR_MAIN) begin
			read_word = sec_main;
		end else if (!cmd_ram && cmd_addr == ISC_ADDR_LEN) begin
			read_word = sec_len;
		end
	end

	// Outgoing word loads after the command byte, shifts on falling edges
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shift_out <= 16'h0000;
		end else if (!frame_on) begin
			shift_out <= 16'h0000;
		end else if (sclk_fall && bit_cnt == ISC_CMD_BITS) begin
			shift_out <= read_word;
		end else if (sclk_fall && bit_cnt > ISC_CMD_BITS) begin
			shift_out <= {shift_out[14:0], 1'b0};
		end
	end

	// Serial out comes from a flop, driven only while selected
	assign o_spi_so = shift_out[15];
	assign o_spi_so_oe = frame_on;

	// Write commits on the last data bit; a short frame writes nothing
	assign wr_commit = sclk_rise && bit_cnt == ISC_FRAME_BITS - 5'h01 && !cmd_read && !cmd_ram;
	assign wr_word = {shift_in[14:0], si_sync[1]};

	// Main register; unused bits are stored as zero whatever the host sends
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sec_main <= ISC_MAIN_RESET;
		end else if (wr_commit && cmd_addr == ISC_ADDR_MAIN) begin
			sec_main <= wr_word & ISC_MAIN_MASK;
		end
	end

	// Length register, same masking for the gap bit
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sec_len <= ISC_LEN_RESET;
		end else if (wr_commit && cmd_addr == ISC_ADDR_LEN) begin
			sec_len <= wr_word & ISC_LEN_MASK;
		end
	end

	// Field views
	assign mode = isc_mode_t'(sec_main[ISC_MODE_LSB +: 2]);
	assign tag_code = sec_main[ISC_TAG_LSB +: 3];
	assign txl = sec_len[ISC_TXL_LSB +: 7];
	assign rxl = sec_len[ISC_RXL_LSB +: 7];

	// Derived datapath configuration
	always_comb begin
		next_cfg = '0;
		next_cfg.mode = mode;
		next_cfg.rx_guard_en = sec_main[ISC_GUARD_BIT];
		next_cfg.sa_key = sec_main[ISC_SAKEY_BIT];
		next_cfg.tx_key = sec_main[ISC_TXKEY_BIT];
		next_cfg.rx_key = sec_main[ISC_RXKEY_BIT];
		// Reserved code gives zero bytes and a flag rather than a guess
		next_cfg.tag_code_bad = tag_code == 3'h0;
		next_cfg.tag_bytes = next_cfg.tag_code_bad ? 5'h00 : {1'b0, tag_code, 1'b0} + ISC_TAG_BASE;
		// CCM runs its own authentication stage, so the head never applies there
		next_cfg.head_en = mode == ISC_MODE_CBCMAC && sec_main[ISC_HEAD_BIT];
		next_cfg.tx_head_byte = {1'b0, i_frame_length} - {1'b0, txl} - ISC_TX_HEAD_ADJ;
		next_cfg.rx_head_byte = {1'b0, rxl};
		// Stand-alone work sees no skip or auth-only lengths; the head bytes still follow them
		if (!i_standalone) begin
			unique case (mode)
				ISC_MODE_OFF: begin
				end
				ISC_MODE_CBCMAC: begin
					next_cfg.tx_clear_skip = txl;
					next_cfg.rx_clear_skip = rxl;
				end
				ISC_MODE_CTR: begin
					next_cfg.tx_clear_skip = txl;
					next_cfg.rx_clear_skip = rxl;
				end
				ISC_MODE_CCM: begin
					next_cfg.tx_auth_only = txl;
					next_cfg.rx_auth_only = rxl;
				end
			endcase
		end
	end

	// Configuration leaves through flops; one cycle behind the registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cfg <= '0;
		end else begin
			o_cfg <= next_cfg;
		end
	end

	// Checks
	a_head_only_cbcmac: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_cfg.head_en |-> o_cfg.mode == ISC_MODE_CBCMAC)
		else $error("head enabled outside plain CBC-MAC");
	a_head_follows_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(mode == ISC_MODE_CBCMAC && sec_main[ISC_HEAD_BIT]) |=> o_cfg.head_en)
		else $error("head not enabled in CBC-MAC with head bit set");
	a_tx_head_calc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> o_cfg.tx_head_byte == 8'($past({1'b0, i_frame_length}) - $past({1'b0, txl}) - 8'h02))
		else $error("transmit head byte wrong");
	a_rx_head_calc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> o_cfg.rx_head_byte == {1'b0, $past(rxl)})
		else $error("receive head byte wrong");
	a_tag_bytes: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> o_cfg.tag_code_bad == ($past(tag_code) == 3'h0)
		&& o_cfg.tag_bytes == ($past(tag_code) == 3'h0 ? 5'h00 : 5'(2 * int'($past(tag_code)) + 2)))
		else $error("tag byte count out of range");
	a_standalone_len: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_standalone) |-> o_cfg.tx_clear_skip == 7'h00 && o_cfg.rx_clear_skip == 7'h00
		&& o_cfg.tx_auth_only == 7'h00 && o_cfg.rx_auth_only == 7'h00)
		else $error("stand-alone saw a length");
	a_ccm_lengths: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(mode == ISC_MODE_CCM && !i_standalone) |=> o_cfg.tx_auth_only == $past(txl)
		&& o_cfg.rx_auth_only == $past(rxl) && o_cfg.tx_clear_skip == 7'h00)
		else $error("CCM lengths wrong");
	a_ctr_lengths: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(mode == ISC_MODE_CTR && !i_standalone) |=> o_cfg.tx_clear_skip == $past(txl)
		&& o_cfg.rx_clear_skip == $past(rxl))
		else $error("CTR lengths wrong");
	a_cbc_lengths: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(mode == ISC_MODE_CBCMAC && !i_standalone) |=> o_cfg.tx_clear_skip == $past(txl)
		&& o_cfg.rx_auth_only == 7'h00)
		else $error("CBC-MAC lengths wrong");
	a_key_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> {o_cfg.sa_key, o_cfg.tx_key, o_cfg.rx_key} == $past(sec_main[7:5]))
		else $error("key selectors wrong");
	a_write_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(sec_main & ~ISC_MAIN_MASK) == 16'h0000 && (sec_len & ~ISC_LEN_MASK) == 16'h0000)
		else $error("unused bits stored");

	c_write_main: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		wr_commit && cmd_addr == ISC_ADDR_MAIN);
	c_read_len: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		sclk_fall && bit_cnt == ISC_CMD_BITS && cmd_read && cmd_addr == ISC_ADDR_LEN);
	c_ccm_mode: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_cfg.mode == ISC_MODE_CCM);
	c_head_used: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_cfg.head_en);

endmodule

// ===== testbench/isc_core_bench.sv
// Self-checking bench for the in-line security control bank.
// Assumes isc_pkg and isc_core are compiled first; the bench drives the serial port itself.
`timescale 1ns/1ns
module isc_core_bench;
	import isc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic csn_n = 1'b1;
	logic sclk = 1'b0;
	logic si = 1'b0;
	logic [6:0] flen = 7'h50;
	logic sa = 1'b0;
	logic so;
	logic so_oe;
	isc_cfg_t cfg;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [15:0] rdv;

	isc_core isc_core_i (
		.i_ref_clk(clk),
		.i_rst_n(rst_n),
		.i_spi_csn_n(csn_n),
		.i_spi_sclk(sclk),
		.i_spi_si(si),
		.o_spi_so(so),
		.o_spi_so_oe(so_oe),
		.i_frame_length(flen),
		.i_standalone(sa),
		.o_cfg(cfg)
	);

	// 100 MHz reference clock
	always #5 clk = ~clk;

	// Hang guard: whole run is about 15 frames of ~310 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("unexpected at %0t: run did not finish", $time);
			results();
		end
	end

	task automatic waitn(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One 24-bit frame; sclk phases of 60 ns leave room for the pin synchronisers
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
		logic [23:0] f;
		f = {cmd, wd};
		rd = 16'h0;
		csn_n = 1'b0;
		waitn(6);
		chk(16'(so_oe), 16'h0001);
		for (int i = 23; i >= 0; i--) begin
			si = f[i];
			waitn(6);
			if (i < 16) rd = {rd[14:0], so};
			sclk = 1'b1;
			waitn(6);
			sclk = 1'b0;
		end
		waitn(6);
		csn_n = 1'b1;
		waitn(8);
		chk(16'(so_oe), 16'h0000);
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		xfer({2'b00, a}, d, rdv);
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
		xfer({2'b01, a}, 16'h0, rdv);
		chk(rdv, exp);
	endtask

	task automatic results();
		if (fail_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence: reset values, masking, every mode, head byte, stand-alone
	initial begin
		waitn(3);
		rst_n = 1'b1;
		waitn(4);
		chk(16'(cfg.mode), 16'h0);
		chk({6'h0, cfg.rx_guard_en, cfg.sa_key, cfg.tx_key, cfg.rx_key, cfg.tag_bytes, cfg.head_en}, 16'h0388);
		rdchk(ISC_ADDR_MAIN, 16'h03c4);
		rdchk(ISC_ADDR_LEN, 16'h0000);
		// Unused bits written as one must not be stored
		wr(ISC_ADDR_MAIN, 16'hffff);
		rdchk(ISC_ADDR_MAIN, 16'h03ff);
		chk(16'({cfg.mode, cfg.head_en}), 16'h0006);
		wr(ISC_ADDR_LEN, 16'hffff);
		rdchk(ISC_ADDR_LEN, 16'h7f7f);
		// Unmapped address holds nothing
		wr(6'h1b, 16'h1234);
		rdchk(6'h1b, 16'h0000);
		// Reserved tag code
		wr(ISC_ADDR_MAIN, 16'h0001);
		chk(16'({cfg.tag_bytes, cfg.tag_code_bad}), 16'h0001);
		chk(16'(cfg.rx_guard_en), 16'h0000);
		wr(ISC_ADDR_LEN, 16'h2513);
		// Every mode with head bit set, key choices and tag codes varied
		for (int k = 0; k < 4; k++) begin
			wr(ISC_ADDR_MAIN, 16'h0100 | 16'(k) | 16'(2 * k + 1) << 2 | 16'(k) << 6);
			chk(16'(cfg.mode), 16'(k));
			chk(16'({cfg.sa_key, cfg.tx_key, cfg.rx_key}), 16'(k << 1));
			chk(16'(cfg.tag_bytes), 16'(4 * k + 4));
			chk(16'(cfg.head_en), 16'(k == 1));
			chk(16'({cfg.tx_clear_skip, 1'b0, cfg.rx_clear_skip}), (k == 1 || k == 2) ? 16'h2513 : 16'h0);
			chk(16'({cfg.tx_auth_only, 1'b0, cfg.rx_auth_only}), (k == 3) ? 16'h2513 : 16'h0);
			chk({cfg.tx_head_byte, cfg.rx_head_byte}, 16'h2913);
		end
		// Stand-alone hides the skip and auth-only lengths, then the skip lengths return
		sa = 1'b1;
		waitn(3);
		chk(16'({cfg.tx_auth_only, 1'b0, cfg.rx_auth_only}), 16'h0);
		wr(ISC_ADDR_MAIN, 16'h0101);
		chk(16'({cfg.tx_clear_skip, 1'b0, cfg.rx_clear_skip}), 16'h0);
		sa = 1'b0;
		waitn(3);
		chk(16'({cfg.tx_clear_skip, 1'b0, cfg.rx_clear_skip}), 16'h2513);
		// Short frame length makes the head byte wrap in 8 bits
		flen = 7'h10;
		waitn(3);
		chk(16'(cfg.tx_head_byte), 16'h00e9);
		results();
	end
endmodule
